// File: hhdt_cfg_store.sv
// Purpose: holds the power limits and the synchronised supply mode
// Assumes: load strobes come from the start-up loader on clk
// Notes: writes after load_done are ignored until the next reset
module hhdt_cfg_store
    import hhdt_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic supply_mode_pin,
    input wire logic cfg_wr_valid,
    input wire logic cfg_wr_sel,
    input wire logic [7:0] cfg_wr_data,
    input wire logic cfg_load_done,
    output logic supply_mode_select,
    output logic [7:0] bus_powered_power_limit,
    output logic [7:0] self_powered_power_limit,
    output logic cfg_ready
);
    logic mode_meta;
    logic next_ready;
    logic [7:0] next_bus;
    logic [7:0] next_self;

    // defaults stand from reset; a serial load overwrites them before done
    always_comb
    begin
        next_bus = bus_powered_power_limit;
        next_self = self_powered_power_limit;
        next_ready = cfg_ready | cfg_load_done;
        if (cfg_wr_valid && !cfg_ready)
        begin
            if (cfg_wr_sel)
                next_self = cfg_wr_data;
            else
                next_bus = cfg_wr_data;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mode_meta <= 1'b0;
            supply_mode_select <= 1'b0;
            bus_powered_power_limit <= DEF_BUS_LIMIT;
            self_powered_power_limit <= DEF_SELF_LIMIT;
            cfg_ready <= 1'b0;
        end
        else
        begin
            mode_meta <= supply_mode_pin;
            supply_mode_select <= mode_meta;
            bus_powered_power_limit <= next_bus;
            self_powered_power_limit <= next_self;
            cfg_ready <= next_ready;
        end
    end
endmodule : hhdt_cfg_store

// File: hhdt_desc_rom.sv
// Purpose: fixed interface and endpoint descriptor bytes, registered read
// Assumes: rd_addr is a configuration-set offset from the same clock
// Notes: bytes outside the fixed tables read as 00h
module hhdt_desc_rom
    import hhdt_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [5:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] next_rd_data;

    function automatic logic [7:0] if_byte(input logic [5:0] rel, input logic multi);
        case (rel)
            F_LENGTH: if_byte = IF_LENGTH;
            F_TYPE: if_byte = IF_TYPE;
            IF_F_NUMBER: if_byte = IF_NUMBER;
            IF_F_ALT: if_byte = multi ? IF_ALT_MULTI : IF_ALT_SINGLE;
            IF_F_NUM_EP: if_byte = IF_NUM_EP;
            IF_F_CLASS: if_byte = IF_CLASS_HUB;
            IF_F_SUBCLASS: if_byte = IF_SUBCLASS;
            IF_F_PROTO: if_byte = multi ? IF_PROTO_MULTI : IF_PROTO_SINGLE;
            IF_F_STRING: if_byte = IF_STRING;
            default: if_byte = 8'h00;
        endcase
    endfunction : if_byte

    // one table serves both alternate settings
    function automatic logic [7:0] ep_byte(input logic [5:0] rel);
        case (rel)
            F_LENGTH: ep_byte = EP_LENGTH;
            F_TYPE: ep_byte = EP_TYPE;
            EP_F_ADDR: ep_byte = EP_ADDR_IN1;
            EP_F_ATTR: ep_byte = EP_ATTR_INTR;
            EP_F_MPS_LO: ep_byte = EP_MAX_PACKET[7:0];
            EP_F_MPS_HI: ep_byte = EP_MAX_PACKET[15:8];
            EP_F_INTERVAL: ep_byte = EP_INTERVAL;
            default: ep_byte = 8'h00;
        endcase
    endfunction : ep_byte

    always_comb
    begin
        next_rd_data = 8'h00;
        if (rd_addr >= OFS_EP_MULTI && rd_addr <= OFS_LAST)
            next_rd_data = ep_byte(6'(rd_addr - OFS_EP_MULTI));
        else if (rd_addr >= OFS_IF_MULTI)
            next_rd_data = if_byte(6'(rd_addr - OFS_IF_MULTI), 1'b1);
        else if (rd_addr >= OFS_EP_SINGLE)
            next_rd_data = ep_byte(6'(rd_addr - OFS_EP_SINGLE));
        else if (rd_addr >= OFS_IF_SINGLE)
            next_rd_data = if_byte(6'(rd_addr - OFS_IF_SINGLE), 1'b0);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rd_data <= 8'h00;
        else
            rd_data <= next_rd_data;
    end
endmodule : hhdt_desc_rom

// File: hhdt_host_model.sv
// Purpose: host-side consumer of the descriptor byte stream
// Assumes: one byte taken per edge with desc_valid and desc_ready high
// Notes: slow mode stalls desc_ready at random
module hhdt_host_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic desc_valid,
    input wire logic [7:0] desc_byte,
    input wire logic [5:0] desc_offset,
    input wire logic desc_last,
    output logic desc_ready
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] got_byte [0:63];
    logic [5:0] got_ofs [0:63];
    int got_cnt;
    int last_idx;
    int seed;
    initial
    begin
        desc_ready = 1'b0;
        got_cnt = 0;
        last_idx = -1;
        seed = 32'h8a63;
    end
    // record each handshake, then pick the next ready level
    always @(posedge clk)
    begin
        if (!rst && desc_valid && desc_ready && got_cnt < 64)
        begin
            got_byte[got_cnt] = desc_byte;
            got_ofs[got_cnt] = desc_offset;
            if (desc_last)
                last_idx = got_cnt;
            got_cnt = got_cnt + 1;
        end
        #1;
        desc_ready <= rst ? 1'b0 : (slow ? ($random(seed) % 3 == 0) : 1'b1);
    end
endmodule : hhdt_host_model

// File: hhdt_pkg.sv
// Purpose: shared constants for the high-speed hub descriptor tables
// Assumes: offsets count bytes from the start of the configuration set
// Notes: one name per number; the state enum lives here too
package hhdt_pkg;
    // ----------------------------------------------------------------
    // offsets inside the configuration set
    // ----------------------------------------------------------------
    localparam int OFS_W = 6;
    localparam logic [5:0] OFS_ATTR = 6'h07;
    localparam logic [5:0] OFS_MAX_POWER = 6'h08;
    localparam logic [5:0] OFS_IF_SINGLE = 6'h09;
    localparam logic [5:0] OFS_EP_SINGLE = 6'h12;
    localparam logic [5:0] OFS_IF_MULTI = 6'h19;
    localparam logic [5:0] OFS_EP_MULTI = 6'h22;
    localparam logic [5:0] OFS_LAST = 6'h28;
    // ----------------------------------------------------------------
    // field positions inside one descriptor
    // ----------------------------------------------------------------
    localparam logic [5:0] F_LENGTH = 6'h00;
    localparam logic [5:0] F_TYPE = 6'h01;
    localparam logic [5:0] IF_F_NUMBER = 6'h02;
    localparam logic [5:0] IF_F_ALT = 6'h03;
    localparam logic [5:0] IF_F_NUM_EP = 6'h04;
    localparam logic [5:0] IF_F_CLASS = 6'h05;
    localparam logic [5:0] IF_F_SUBCLASS = 6'h06;
    localparam logic [5:0] IF_F_PROTO = 6'h07;
    localparam logic [5:0] IF_F_STRING = 6'h08;
    localparam logic [5:0] EP_F_ADDR = 6'h02;
    localparam logic [5:0] EP_F_ATTR = 6'h03;
    localparam logic [5:0] EP_F_MPS_LO = 6'h04;
    localparam logic [5:0] EP_F_MPS_HI = 6'h05;
    localparam logic [5:0] EP_F_INTERVAL = 6'h06;
    // ----------------------------------------------------------------
    // field values
    // ----------------------------------------------------------------
    localparam logic [7:0] IF_LENGTH = 8'h09;
    localparam logic [7:0] IF_TYPE = 8'h04;
    localparam logic [7:0] IF_NUMBER = 8'h00;
    localparam logic [7:0] IF_ALT_SINGLE = 8'h00;
    localparam logic [7:0] IF_ALT_MULTI = 8'h01;
    localparam logic [7:0] IF_NUM_EP = 8'h01;
    localparam logic [7:0] IF_CLASS_HUB = 8'h09;
    localparam logic [7:0] IF_SUBCLASS = 8'h00;
    localparam logic [7:0] IF_PROTO_SINGLE = 8'h01;
    localparam logic [7:0] IF_PROTO_MULTI = 8'h02;
    localparam logic [7:0] IF_STRING = 8'h00;
    localparam logic [7:0] EP_LENGTH = 8'h07;
    localparam logic [7:0] EP_TYPE = 8'h05;
    localparam logic [7:0] EP_ADDR_IN1 = 8'h81;
    localparam logic [7:0] EP_ATTR_INTR = 8'h03;
    localparam logic [15:0] EP_MAX_PACKET = 16'h0001;
    localparam logic [7:0] EP_INTERVAL = 8'h0C;
    localparam logic [7:0] ATTR_BUS = 8'hA0;
    localparam logic [7:0] ATTR_SELF = 8'hE0;
    // ----------------------------------------------------------------
    // reset values of the stored power limits (2 mA units, plain defaults)
    // ----------------------------------------------------------------
    localparam logic [7:0] DEF_BUS_LIMIT = 8'h01;
    localparam logic [7:0] DEF_SELF_LIMIT = 8'h01;
    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_FETCH = 4'b0010,
        ST_LOAD = 4'b0100,
        ST_SEND = 4'b1000
    } hhdt_state_type;
endpackage : hhdt_pkg

// File: hhdt_top.sv
// Purpose: streams the tail of the high-speed configuration set to the host side
// Assumes: set_req and desc_ready come from upstream logic on clk
// Notes: one byte per handshake, offsets 07h to 28h in ascending order
//
// Behaviour
// - maximum-power byte counts in 2 mA steps, covering all hub circuitry.
// - mode bit 0 reports the bus limit, 1 reports the self limit.
// - both limits come from the stored field, defaults or serial load.
// - interface descriptors are 9 bytes, type 04h, interface number 00h.
// - alternate setting 00h for single translator, 01h for multiple.
// - protocol 01h for single translator, 02h for multiple.
// - each interface has one endpoint, class 09h, subclass 00h.
// - interface string index is 00h in both interfaces.
// - endpoint descriptor is 7 bytes, type 05h, address 81h.
// - endpoint attributes are 03h, interrupt data endpoint.
// - endpoint maximum packet size is 0001h.
// - endpoint polling interval is 0Ch.
// - both alternate settings carry the same endpoint descriptor.
// - attributes read A0h when bus powered, E0h when self powered.
module hhdt_top
    import hhdt_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic supply_mode_pin,
    input wire logic cfg_wr_valid,
    input wire logic cfg_wr_sel,
    input wire logic [7:0] cfg_wr_data,
    input wire logic cfg_load_done,
    input wire logic set_req,
    input wire logic desc_ready,
    output logic desc_valid,
    output logic [7:0] desc_byte,
    output logic [5:0] desc_offset,
    output logic desc_last,
    output logic busy,
    output logic cfg_ready
);
    hhdt_state_type state;
    hhdt_state_type next_state;
    logic [5:0] addr;
    logic [5:0] next_addr;
    logic next_valid;
    logic [7:0] next_byte;
    logic [5:0] next_offset;
    logic next_last;
    logic next_busy;
    logic [7:0] rom_data;
    logic supply_mode_select;
    logic [7:0] bus_powered_power_limit;
    logic [7:0] self_powered_power_limit;

    // ----------------------------------------------------------------
    // stored configuration and fixed tables
    // ----------------------------------------------------------------
    hhdt_cfg_store u_store (
        .clk(clk),
        .rst(rst),
        .supply_mode_pin(supply_mode_pin),
        .cfg_wr_valid(cfg_wr_valid),
        .cfg_wr_sel(cfg_wr_sel),
        .cfg_wr_data(cfg_wr_data),
        .cfg_load_done(cfg_load_done),
        .supply_mode_select(supply_mode_select),
        .bus_powered_power_limit(bus_powered_power_limit),
        .self_powered_power_limit(self_powered_power_limit),
        .cfg_ready(cfg_ready)
    );

    hhdt_desc_rom u_rom (
        .clk(clk),
        .rst(rst),
        .rd_addr(addr),
        .rd_data(rom_data)
    );

    // ----------------------------------------------------------------
    // byte sequencer
    // ----------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        next_addr = addr;
        next_valid = desc_valid;
        next_byte = desc_byte;
        next_offset = desc_offset;
        next_last = desc_last;
        next_busy = busy;
        case (state)
            ST_IDLE:
            begin
                // requests before the limits are settled are ignored
                if (set_req && cfg_ready)
                begin
                    next_addr = OFS_ATTR;
                    next_busy = 1'b1;
                    next_state = ST_FETCH;
                end
            end
            ST_FETCH:
                next_state = ST_LOAD;
            ST_LOAD:
            begin
                if (addr == OFS_ATTR)
                    next_byte = supply_mode_select ? ATTR_SELF : ATTR_BUS;
                else if (addr == OFS_MAX_POWER)
                    next_byte = supply_mode_select ? self_powered_power_limit
                                                   : bus_powered_power_limit;
                else
                    next_byte = rom_data;
                next_offset = addr;
                next_last = (addr == OFS_LAST);
                next_valid = 1'b1;
                next_state = ST_SEND;
            end
            ST_SEND:
            begin
                if (desc_ready)
                begin
                    next_valid = 1'b0;
                    if (desc_last)
                    begin
                        next_busy = 1'b0;
                        next_last = 1'b0;
                        next_state = ST_IDLE;
                    end
                    else
                    begin
                        next_addr = 6'(addr + 6'h01);
                        next_state = ST_FETCH;
                    end
                end
            end
            default:
            begin
                next_state = ST_IDLE;
                next_valid = 1'b0;
                next_busy = 1'b0;
                next_last = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state <= ST_IDLE;
            addr <= 6'h00;
            desc_valid <= 1'b0;
            desc_byte <= 8'h00;
            desc_offset <= 6'h00;
            desc_last <= 1'b0;
            busy <= 1'b0;
        end
        else
        begin
            state <= next_state;
            addr <= next_addr;
            desc_valid <= next_valid;
            desc_byte <= next_byte;
            desc_offset <= next_offset;
            desc_last <= next_last;
            busy <= next_busy;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic load_mode;
    logic [5:0] prev_offset;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            load_mode <= 1'b0;
            prev_offset <= 6'h00;
        end
        else
        begin
            if (state == ST_LOAD)
                load_mode <= supply_mode_select;
            if (desc_valid && desc_ready)
                prev_offset <= desc_offset;
        end
    end

    property p_power_bus;
        @(posedge clk) disable iff (rst)
        desc_valid && desc_offset == OFS_MAX_POWER && !load_mode
            |-> desc_byte == bus_powered_power_limit;
    endproperty
    a_power_bus: assert property (p_power_bus) else $error("bus limit not reported");

    property p_power_self;
        @(posedge clk) disable iff (rst)
        desc_valid && desc_offset == OFS_MAX_POWER && load_mode
            |-> desc_byte == self_powered_power_limit;
    endproperty
    a_power_self: assert property (p_power_self) else $error("self limit not reported");

    property p_attr;
        @(posedge clk) disable iff (rst)
        desc_valid && desc_offset == OFS_ATTR
            |-> desc_byte == (load_mode ? ATTR_SELF : ATTR_BUS);
    endproperty
    a_attr: assert property (p_attr) else $error("attributes do not match mode");

    property p_if_head;
        @(posedge clk) disable iff (rst)
        desc_valid && desc_ready
            && (desc_offset == OFS_IF_SINGLE || desc_offset == OFS_IF_MULTI)
            |-> desc_byte == IF_LENGTH ##1 !desc_valid [*2] ##1 desc_byte == IF_TYPE;
    endproperty
    a_if_head: assert property (p_if_head) else $error("interface header wrong");

    property p_alt;
        @(posedge clk) disable iff (rst)
        desc_valid && (desc_offset == OFS_IF_SINGLE + IF_F_ALT
            || desc_offset == OFS_IF_MULTI + IF_F_ALT)
            |-> desc_byte == (desc_offset == OFS_IF_MULTI + IF_F_ALT ? IF_ALT_MULTI : IF_ALT_SINGLE);
    endproperty
    a_alt: assert property (p_alt) else $error("alternate setting wrong");

    property p_proto;
        @(posedge clk) disable iff (rst)
        desc_valid && desc_offset == OFS_IF_MULTI + IF_F_PROTO |-> desc_byte == IF_PROTO_MULTI;
    endproperty
    a_proto: assert property (p_proto) else $error("multi protocol wrong");

    property p_proto_single;
        @(posedge clk) disable iff (rst)
        desc_valid && desc_offset == OFS_IF_SINGLE + IF_F_PROTO
            |-> desc_byte == IF_PROTO_SINGLE;
    endproperty
    a_proto_single: assert property (p_proto_single) else $error("single protocol wrong");

    property p_class;
        @(posedge clk) disable iff (rst)
        desc_valid && desc_offset == OFS_IF_SINGLE + IF_F_CLASS |-> desc_byte == IF_CLASS_HUB;
    endproperty
    a_class: assert property (p_class) else $error("hub class wrong");

    property p_string;
        @(posedge clk) disable iff (rst)
        desc_valid && desc_offset == OFS_IF_MULTI + IF_F_STRING |-> desc_byte == IF_STRING;
    endproperty
    a_string: assert property (p_string) else $error("string index wrong");

    property p_ep_addr;
        @(posedge clk) disable iff (rst)
        desc_valid && (desc_offset == OFS_EP_SINGLE + EP_F_ADDR
            || desc_offset == OFS_EP_MULTI + EP_F_ADDR) |-> desc_byte == EP_ADDR_IN1;
    endproperty
    a_ep_addr: assert property (p_ep_addr) else $error("endpoint address wrong");

    property p_ep_attr;
        @(posedge clk) disable iff (rst)
        desc_valid && desc_offset == OFS_EP_SINGLE + EP_F_ATTR |-> desc_byte == EP_ATTR_INTR;
    endproperty
    a_ep_attr: assert property (p_ep_attr) else $error("endpoint attributes wrong");

    property p_mps;
        @(posedge clk) disable iff (rst)
        desc_valid && desc_ready && desc_offset == OFS_EP_MULTI + EP_F_MPS_LO
            |-> desc_byte == EP_MAX_PACKET[7:0] ##3 desc_byte == EP_MAX_PACKET[15:8];
    endproperty
    a_mps: assert property (p_mps) else $error("max packet size wrong");

    property p_interval;
        @(posedge clk) disable iff (rst)
        desc_valid && desc_offset == OFS_EP_MULTI + EP_F_INTERVAL |-> desc_byte == EP_INTERVAL;
    endproperty
    a_interval: assert property (p_interval) else $error("interval wrong");

    property p_order;
        @(posedge clk) disable iff (rst)
        desc_valid && desc_ready && !desc_last
            |=> !desc_valid [*2] ##1 desc_valid && desc_offset == 6'(prev_offset + 6'h01);
    endproperty
    a_order: assert property (p_order) else $error("offsets not ascending");

    property p_start;
        @(posedge clk) disable iff (rst)
        !busy && set_req && cfg_ready |-> ##3 desc_valid && desc_offset == OFS_ATTR;
    endproperty
    a_start: assert property (p_start) else $error("set does not start at attributes");

    property p_hold;
        @(posedge clk) disable iff (rst)
        desc_valid && !desc_ready |=> desc_valid && $stable(desc_byte) && $stable(desc_offset);
    endproperty
    a_hold: assert property (p_hold) else $error("byte dropped under stall");

    property p_ep_len;
        @(posedge clk) disable iff (rst)
        desc_valid && (desc_offset == OFS_EP_SINGLE || desc_offset == OFS_EP_MULTI)
            |-> desc_byte == EP_LENGTH;
    endproperty
    a_ep_len: assert property (p_ep_len) else $error("endpoint length wrong");

    // the last flag marks exactly the final offset of the set
    property p_last;
        @(posedge clk) disable iff (rst)
        desc_valid |-> desc_last == (desc_offset == OFS_LAST);
    endproperty
    a_last: assert property (p_last) else $error("last flag misplaced");

    c_full_set: cover property (@(posedge clk) disable iff (rst) desc_valid && desc_ready && desc_last);
    c_self: cover property (@(posedge clk) disable iff (rst)
        desc_valid && desc_offset == OFS_MAX_POWER && load_mode);
    c_stall: cover property (@(posedge clk) disable iff (rst) desc_valid && !desc_ready [*3]);
    c_multi_alt: cover property (@(posedge clk) disable iff (rst)
        desc_valid && desc_ready && desc_offset == OFS_IF_MULTI + IF_F_ALT);
endmodule : hhdt_top

// File: hub_hs_descriptor_tables_tb.sv
// Purpose: self-checking bench for the descriptor stream
// Assumes: hand-over latencies; one load per reset
// Notes: random limits and stalls from a fixed seed
module hub_hs_descriptor_tables_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import hhdt_pkg::*;
    logic clk, rst, supply_mode_pin, cfg_wr_valid, cfg_wr_sel, cfg_load_done;
    logic set_req, desc_ready, desc_valid, desc_last, busy, cfg_ready, slow;
    logic [7:0] cfg_wr_data, desc_byte, bl, sl;
    logic [5:0] desc_offset;
    int err_total, checks_done, seed, k;
    hhdt_top i_hhdt_top (.clk(clk), .rst(rst), .supply_mode_pin(supply_mode_pin),
        .cfg_wr_valid(cfg_wr_valid), .cfg_wr_sel(cfg_wr_sel), .cfg_wr_data(cfg_wr_data),
        .cfg_load_done(cfg_load_done), .set_req(set_req), .desc_ready(desc_ready),
        .desc_valid(desc_valid), .desc_byte(desc_byte), .desc_offset(desc_offset),
        .desc_last(desc_last), .busy(busy), .cfg_ready(cfg_ready));
    hhdt_host_model i_hhdt_host_model (.clk(clk), .rst(rst), .slow(slow),
        .desc_valid(desc_valid), .desc_byte(desc_byte), .desc_offset(desc_offset),
        .desc_last(desc_last), .desc_ready(desc_ready));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk
    function automatic logic [7:0] exp_byte(input int ofs, input logic mode);
        logic m;
        if (ofs == 7)
            return mode ? 8'hE0 : 8'hA0;
        if (ofs == 8)
            return mode ? sl : bl;
        m = (ofs >= 25);
        case ((ofs - 9) % 16)
            0: return 8'h09;
            1: return 8'h04;
            3: return m ? 8'h01 : 8'h00;
            4: return 8'h01;
            5: return 8'h09;
            7: return m ? 8'h02 : 8'h01;
            9: return 8'h07;
            10: return 8'h05;
            11: return 8'h81;
            12: return 8'h03;
            13: return 8'h01;
            15: return 8'h0C;
            default: return 8'h00;
        endcase
    endfunction : exp_byte
    task tick();
        @(posedge clk);
        #1;
    endtask : tick
    task load(input bit keep_defaults);
        if (!keep_defaults)
        begin
            tick();
            cfg_wr_valid = 1'b1;
            cfg_wr_sel = 1'b0;
            cfg_wr_data = bl;
            tick();
            cfg_wr_sel = 1'b1;
            cfg_wr_data = sl;
        end
        tick();
        cfg_wr_valid = 1'b0;
        cfg_load_done = 1'b1;
        tick();
        cfg_load_done = 1'b0;
        chk({7'h0, cfg_ready}, 8'h01, "cfg_ready after load");
        cfg_wr_valid = 1'b1;
        cfg_wr_sel = 1'b1;
        cfg_wr_data = ~sl;
        tick();
        cfg_wr_valid = 1'b0;
    endtask : load
    task stream(input logic mode);
        int n;
        supply_mode_pin = mode;
        repeat (4) tick();
        i_hhdt_host_model.got_cnt = 0;
        i_hhdt_host_model.last_idx = -1;
        set_req = 1'b1;
        tick();
        set_req = 1'b0;
        chk({7'h0, busy}, 8'h01, "busy after take");
        tick();
        chk({7'h0, desc_valid}, 8'h00, "valid too early");
        tick();
        chk({7'h0, desc_valid}, 8'h01, "first byte latency");
        repeat (5) tick();
        set_req = 1'b1;
        tick();
        set_req = 1'b0;
        n = 0;
        while ((busy === 1'b1) && n < 2000)
        begin
            tick();
            n++;
        end
        chk({7'h0, busy}, 8'h00, "stream did not finish");
        chk(i_hhdt_host_model.got_cnt[7:0], 8'd34, "byte count");
        chk(i_hhdt_host_model.last_idx[7:0], 8'd33, "last flag position");
        for (n = 0; n < 34 && n < i_hhdt_host_model.got_cnt; n++)
        begin
            chk({2'b0, i_hhdt_host_model.got_ofs[n]}, 8'(n + 7), "offset order");
            chk(i_hhdt_host_model.got_byte[n], exp_byte(n + 7, mode), "byte");
        end
        repeat (8) tick();
        chk({7'h0, desc_valid}, 8'h00, "request while busy was taken");
        $display("test stream mode %0d slow %0d done", mode, slow);
    endtask : stream
    task results();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results
    // ----------------------------------------------------------------
    // clock, watchdog and main sequence
    // ----------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        #400us;
        err_total++;
        $display("wrong value at %0t: watchdog expired", $time);
        results();
    end
    initial
    begin
        {rst, supply_mode_pin, cfg_wr_valid, cfg_wr_sel, cfg_load_done, set_req, slow} = '0;
        cfg_wr_data = 8'h00;
        err_total = 0;
        checks_done = 0;
        seed = 32'h8a63;
        for (k = 0; k < 5; k++)
        begin
            rst = 1'b1;
            repeat (20) @(posedge clk);
            #1;
            rst = 1'b0;
            chk({desc_valid, busy, cfg_ready, desc_last, 4'h0}, 8'h00, "outputs after reset");
            set_req = 1'b1;
            tick();
            set_req = 1'b0;
            repeat (3) tick();
            chk({7'h0, busy}, 8'h00, "request before load taken");
            bl = $random(seed);
            sl = $random(seed);
            if (k == 1)
            begin
                bl = 8'h00;
                sl = 8'hFF;
            end
            if (k == 0)
            begin
                bl = 8'h01;
                sl = 8'h01;
            end
            load(k == 0);
            slow = k[0];
            stream(1'b0);
            stream(1'b1);
            slow = ~slow;
            stream(1'($random(seed)));
        end
        results();
    end
endmodule : hub_hs_descriptor_tables_tb
